// ### sim/capture_event_source.sv
// Behavioural source of capture events on the input pins
`timescale 1ns/10ps
module capture_event_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] fire,
  output logic      [3:0] capture_input_pin
);
  // Each request is registered onto its pin one cycle later, so a one-cycle request gives a clean rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_input_pin <= 4'h0;
    end else begin
      capture_input_pin <= fire;
    end
  end
endmodule

// ### sim/capture_readout_overflow_asserts.sv
// Port-level checker of the capture readout block
`timescale 1ns/10ps
module capture_readout_overflow_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        irq,
  input wire logic [3:0]  capture_input_pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Steps of one register transfer
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  chk_answer_next: assert property (s_wait |=> s_done)
    else $error("access phase not answered in the next cycle");
  chk_answer_once: assert property (s_done |=> !pready)
    else $error("pready held beyond one cycle");
  chk_answer_cause: assert property (!(psel && penable) |=> !pready)
    else $error("pready without an access phase");
  chk_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above the low byte");
  // Interrupt moves only after an event or a completed write
  chk_irq_rise: assert property ($rose(irq) |-> $past(capture_input_pin, 1) != 4'h0
    || $past(psel && penable && pready && pwrite, 2))
    else $error("interrupt rose without an event or a write");
  chk_irq_fall: assert property ($fell(irq) |->
    $past(psel && penable && pready && pwrite, 1)
    || $past(psel && penable && pready && pwrite, 2))
    else $error("interrupt fell without a write");
endmodule
bind capture_readout_overflow capture_readout_overflow_asserts chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .irq(irq), .capture_input_pin(capture_input_pin));

// ### sim/capture_readout_overflow_bench.sv
// Self-checking testbench of the capture readout block
`timescale 1ns/10ps
module capture_readout_overflow_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  fire, capture_input_pin;
  logic [7:0]  rv;
  int          err_total, checks;
  capture_readout_overflow DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .irq(irq),
    .capture_input_pin(capture_input_pin));
  capture_event_source src (
    .pclk(pclk), .presetn(presetn), .fire(fire), .capture_input_pin(capture_input_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // One register transfer; read data lands in rv
  task automatic apb(input int wr, input logic [4:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= (wr != 0);
    paddr   <= {25'h0, idx, 2'h0};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rv = prdata[7:0];
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // One event pulse on a channel, then time for it to land
  task automatic ev(input int ch);
    @(posedge pclk);
    fire <= 4'h1 << ch;
    @(posedge pclk);
    fire <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask
  // Capture, interrupt and overflow walk of one channel
  task automatic chan(input int ch, input logic [3:0] cb, ob, fb, input logic [4:0] ci, oi, fi,
                      input int obit, fbit);
    logic [7:0] om, fm, lo;
    om = 8'h1 << obit;
    fm = 8'h1 << fbit;
    lo = 8'hA0 | 8'(ch);
    apb(1, 5'h0F, 8'h02);
    apb(1, 5'h12, lo);
    apb(1, 5'h13, 8'hC5);
    ev(ch);
    apb(1, 5'h0F, {4'h0, fb});
    apb(0, fi, 8'h0);
    chk("irq flag", fm, rv & fm);
    apb(1, fi + 5'h1, fm);
    repeat (2) @(posedge pclk);
    chk("irq out", 8'h1, {7'h0, irq});
    apb(1, fi + 5'h1, 8'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 8'h0, {7'h0, irq});
    apb(1, fi, fm);
    apb(0, fi, 8'h0);
    chk("irq cleared", 8'h0, rv & fm);
    apb(1, 5'h0F, 8'h02);
    apb(1, 5'h12, 8'h5A);
    ev(ch); // Second event while the word is unread
    apb(1, 5'h0F, {4'h0, ob});
    apb(0, oi, 8'h0);
    chk("ovf hidden", 8'h0, rv & om);
    apb(1, 5'h0F, {4'h0, cb});
    apb(0, ci + 5'h1, 8'h0);
    chk("cap high", 8'hC5, rv);
    apb(0, ci, 8'h0);
    chk("cap low", lo, rv);
    apb(1, 5'h0F, {4'h0, ob});
    apb(0, oi, 8'h0);
    chk("ovf set", om, rv & om);
    ev(ch);
    apb(1, 5'h0F, {4'h0, cb});
    apb(0, ci, 8'h0);
    chk("cap fresh", 8'h5A, rv);
    apb(0, ci + 5'h1, 8'h0);
    chk("cap fresh high", 8'hC5, rv);
    apb(1, 5'h0F, {4'h0, ob});
    apb(0, oi, 8'h0);
    chk("ovf cleared", 8'h0, rv & om);
    apb(1, 5'h0F, {4'h0, fb});
    apb(0, fi, 8'h0);
    chk("irq flag again", fm, rv & fm);
  endtask
  task automatic summarize();
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns period
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    $display("unexpected watchdog: expected finish, seen timeout");
    summarize();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fire} = '0;
    err_total = 0;
    checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1, 5'h0F, 8'h04);
    apb(0, 5'h10, 8'h0);
    chk("flags_b reset", 8'h02, rv);
    apb(0, 5'h11, 8'h0);
    chk("enables_b reset", 8'h00, rv);
    apb(1, 5'h0F, 8'h0D);
    apb(0, 5'h12, 8'h0);
    chk("unbanked read", 8'h00, rv);
    apb(1, 5'h0F, 8'h03);
    apb(0, 5'h17, 8'h0);
    chk("status reset", 8'h00, rv);
    apb(1, 5'h0F, 8'h02);
    apb(1, 5'h16, 8'h3C);
    apb(0, 5'h16, 8'h0);
    chk("period low", 8'h3C, rv);
    ev(0); // Period mode: channel one ignores its pin
    apb(1, 5'h0F, 8'h01);
    apb(0, 5'h16, 8'h0);
    chk("ch1 flag idle", 8'h00, rv & 8'h04);
    apb(1, 5'h0F, 8'h03);
    apb(1, 5'h17, 8'h08); // Channel one captures, timebase halted
    chan(0, 4'h2, 4'h3, 4'h1, 5'h16, 5'h17, 5'h16, 6, 2);
    chan(1, 4'h3, 4'h3, 4'h1, 5'h14, 5'h17, 5'h16, 7, 3);
    chan(2, 4'h7, 4'h7, 4'h4, 5'h12, 5'h16, 5'h10, 5, 2);
    chan(3, 4'h7, 4'h7, 4'h4, 5'h14, 5'h16, 5'h10, 6, 3);
    summarize();
  end
endmodule

// ### src/capture_readout_overflow.sv
// Four-channel capture readout with double-buffered overflow flags
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "capture_readout_params.svh"

// What this block does
// - Overflow per channel kept as hidden master flag and visible slave flag.
// - Event while capture word is unread sets that channel's master flag.
// - Event while capture word is unread does not overwrite the capture value.
// - After both bytes are read, master copies to slave and master clears on the same edge.
module capture_readout_overflow (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            irq,
  input  wire logic [3:0]                 capture_input_pin
);

  //////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic                            pready_q;
  logic [31:0]                     prdata_q;
  logic                            irq_q;
  capture_readout_pkg::bank_t      bank_q;
  capture_readout_pkg::byte_t      irq_flags_a_q;
  capture_readout_pkg::byte_t      irq_flags_b_q;
  capture_readout_pkg::byte_t      irq_en_a_q;
  capture_readout_pkg::byte_t      irq_en_b_q;
  capture_readout_pkg::byte_t      edge_ctrl_q;
  capture_readout_pkg::byte_t      run_ctrl_q;
  capture_readout_pkg::byte_t      upper_ctrl_q;
  capture_readout_pkg::cap_word_t  timebase_q;
  capture_readout_pkg::cap_word_t  period_q;
  capture_readout_pkg::cap_word_t  cap_q [4];
  logic [3:0]                      full_q;
  logic [3:0]                      master_q;
  logic [3:0]                      slave_q;
  logic [3:0]                      got_lo_q;
  logic [3:0]                      got_hi_q;
  logic [3:0]                      pin_q;

  wire capture_readout_pkg::reg_idx_t idx = paddr[6:2];
  wire        addr_ok = (paddr[31:7] == 25'h0000000) && (paddr[1:0] == 2'h0);
  wire        setup_acc = psel && penable && !pready_q;
  wire        done = psel && penable && pready_q;
  wire        wr = done && pwrite && addr_ok;
  wire        rd = done && !pwrite && addr_ok;
  wire [7:0]  wb = pwdata[7:0];

  // Bank and register hit decode
  wire b_a = (bank_q == `BANK_IRQ_A);
  wire b_t = (bank_q == `BANK_TIMEBASE);
  wire b_c = (bank_q == `BANK_TIMER_CTRL);
  wire b_b = (bank_q == `BANK_IRQ_B);
  wire b_u = (bank_q == `BANK_UPPER);
  wire hit_bank  = (idx == `IDX_BANK_SELECT);
  wire hit_fl_b  = b_b && (idx == `IDX_IRQ_FLAGS_B);
  wire hit_en_b  = b_b && (idx == `IDX_IRQ_ENABLES_B);
  wire hit_fl_a  = b_a && (idx == `IDX_IRQ_FLAGS_A);
  wire hit_en_a  = b_a && (idx == `IDX_IRQ_ENABLES_A);
  wire hit_tb_lo = b_t && (idx == `IDX_TB_LOW);
  wire hit_tb_hi = b_t && (idx == `IDX_TB_HIGH);
  wire hit_p1_lo = b_t && (idx == `IDX_PER_CH1_LOW);
  wire hit_p1_hi = b_t && (idx == `IDX_PER_CH1_HIGH);
  wire hit_edge  = b_c && (idx == `IDX_EDGE_CLOCK_CTRL);
  wire hit_run   = b_c && (idx == `IDX_RUN_OVF_STATUS);
  wire hit_upper = b_u && (idx == `IDX_UPPER_CTRL);
  wire cap1_sel  = run_ctrl_q[`BIT_PERIOD_CAP_SEL];

  // Per-channel byte hits; channel one pair only in capture mode
  wire [3:0] hit_lo = {b_u && (idx == `IDX_CH4_LOW),
                       b_u && (idx == `IDX_CH3_LOW),
                       b_c && (idx == `IDX_CH2_LOW),
                       hit_p1_lo && cap1_sel};
  wire [3:0] hit_hi = {b_u && (idx == `IDX_CH4_HIGH),
                       b_u && (idx == `IDX_CH3_HIGH),
                       b_c && (idx == `IDX_CH2_HIGH),
                       hit_p1_hi && cap1_sel};

  //////////////////////////////////////////////////////////////////////////
  // Read data selection

  // Status bytes: slave flags placed at their field positions
  wire [7:0] ovf_lo_pos = ((8'h01 << `BIT_CH2_OVF) & {8{slave_q[1]}})
                        | ((8'h01 << `BIT_CH1_OVF) & {8{slave_q[0]}});
  wire [7:0] ovf_hi_pos = ((8'h01 << `BIT_CH4_OVF) & {8{slave_q[3]}})
                        | ((8'h01 << `BIT_CH3_OVF) & {8{slave_q[2]}});
  wire [7:0] run_rd     = ovf_lo_pos | {2'b00, run_ctrl_q[5:0]};
  wire [7:0] upper_rd   = ovf_hi_pos | {3'b000, upper_ctrl_q[4:0]};

  // One term per register; at most one hit is active at a time
  wire [7:0] rd_bank  = hit_bank  ? {4'h0, bank_q}   : 8'h00;
  wire [7:0] rd_fl_b  = hit_fl_b  ? irq_flags_b_q    : 8'h00;
  wire [7:0] rd_en_b  = hit_en_b  ? irq_en_b_q       : 8'h00;
  wire [7:0] rd_fl_a  = hit_fl_a  ? irq_flags_a_q    : 8'h00;
  wire [7:0] rd_en_a  = hit_en_a  ? irq_en_a_q       : 8'h00;
  wire [7:0] rd_tb_lo = hit_tb_lo ? timebase_q[7:0]  : 8'h00;
  wire [7:0] rd_tb_hi = hit_tb_hi ? timebase_q[15:8] : 8'h00;
  wire [7:0] rd_pr_lo = (hit_p1_lo && !cap1_sel) ? period_q[7:0]  : 8'h00;
  wire [7:0] rd_pr_hi = (hit_p1_hi && !cap1_sel) ? period_q[15:8] : 8'h00;
  wire [7:0] rd_edge  = hit_edge  ? edge_ctrl_q      : 8'h00;
  wire [7:0] rd_run   = hit_run   ? run_rd           : 8'h00;
  wire [7:0] rd_upper = hit_upper ? upper_rd         : 8'h00;
  wire [7:0] rd_cap [4];

  // Capture bytes, one term per channel
  genvar r;
  generate
    for (r = 0; r < 4; r = r + 1) begin : g_rd
      assign rd_cap[r] = (hit_lo[r] ? cap_q[r][7:0]  : 8'h00)
                       | (hit_hi[r] ? cap_q[r][15:8] : 8'h00);
    end
  endgenerate

  wire [7:0] rmux = rd_bank | rd_fl_b | rd_en_b | rd_fl_a | rd_en_a
                  | rd_tb_lo | rd_tb_hi | rd_pr_lo | rd_pr_hi | rd_edge
                  | rd_run | rd_upper
                  | rd_cap[0] | rd_cap[1] | rd_cap[2] | rd_cap[3];

  //////////////////////////////////////////////////////////////////////////
  // Capture events and readout sequence

  wire [3:0] event_w = capture_input_pin & ~pin_q;
  wire [3:0] rd_lo = {4{rd}} & hit_lo;
  wire [3:0] rd_hi = {4{rd}} & hit_hi;
  wire [3:0] pair_done = (got_lo_q | rd_lo) & (got_hi_q | rd_hi);
  // Channel one captures only while its pair serves capture
  wire [3:0] cap_en = {3'b111, cap1_sel};
  wire [3:0] ev_q = event_w & cap_en;
  wire [3:0] load = ev_q & (~full_q | pair_done);
  wire [3:0] over = ev_q & full_q & ~pair_done;

  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_ch
      // Capture word, loaded while empty or in the cycle its pair read completes
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cap_q[c] <= 16'h0000;
        end else if (load[c]) begin
          cap_q[c] <= timebase_q;
        end
      end
    end
  endgenerate

  // Occupancy and byte-read tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q   <= 4'h0;
      got_lo_q <= 4'h0;
      got_hi_q <= 4'h0;
    end else begin
      full_q   <= (full_q & ~pair_done) | load;
      got_lo_q <= (got_lo_q | rd_lo) & ~pair_done;
      got_hi_q <= (got_hi_q | rd_hi) & ~pair_done;
    end
  end

  // Master set by hardware, slave loaded only by a finished pair read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_q <= 4'h0;
      slave_q  <= 4'h0;
    end else begin
      master_q <= (master_q & ~pair_done) | over;
      slave_q  <= (slave_q & ~pair_done) | (master_q & pair_done);
    end
  end

  // Pin history for rising-edge events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 4'h0;
    end else begin
      pin_q <= capture_input_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timebase and period

  wire tb_run = run_ctrl_q[`BIT_TIMEBASE_RUN];

  // Counter that counts only while the timebase run bit is set, byte-writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timebase_q <= 16'h0000;
    end else if (wr && hit_tb_lo) begin
      timebase_q <= {timebase_q[15:8], wb};
    end else if (wr && hit_tb_hi) begin
      timebase_q <= {wb, timebase_q[7:0]};
    end else if (tb_run) begin
      timebase_q <= timebase_q + 16'h0001;
    end
  end

  // Period register shares the channel one pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q <= 16'h0000;
    end else if (wr && hit_p1_lo && !cap1_sel) begin
      period_q <= {period_q[15:8], wb};
    end else if (wr && hit_p1_hi && !cap1_sel) begin
      period_q <= {wb, period_q[7:0]};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  // Write strobes of the plain registers
  wire wr_bank  = wr && hit_bank;
  wire wr_edge  = wr && hit_edge;
  wire wr_run   = wr && hit_run;
  wire wr_upper = wr && hit_upper;
  wire wr_en_a  = wr && hit_en_a;
  wire wr_en_b  = wr && hit_en_b;

  // Bank select for the shared indices
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q <= `RST_BANK;
    end else if (wr_bank) begin
      bank_q <= wb[3:0];
    end
  end

  // Edge control, plain storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_ctrl_q <= `RST_TIMER_CTRL;
    end else if (wr_edge) begin
      edge_ctrl_q <= wb;
    end
  end

  // Run control; the two overflow bits are read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ctrl_q <= `RST_TIMER_CTRL;
    end else if (wr_run) begin
      run_ctrl_q <= {2'b00, wb[5:0]};
    end
  end

  // Upper control; top three bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_ctrl_q <= `RST_TIMER_CTRL;
    end else if (wr_upper) begin
      upper_ctrl_q <= {3'b000, wb[4:0]};
    end
  end

  // Interrupt enables, first group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_a_q <= `RST_IRQ_ENABLES;
    end else if (wr_en_a) begin
      irq_en_a_q <= wb;
    end
  end

  // Interrupt enables, second group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_b_q <= `RST_IRQ_ENABLES;
    end else if (wr_en_b) begin
      irq_en_b_q <= wb;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt flags: set by a fresh capture, write one to clear, set wins

  wire [7:0] set_a = (8'h01 << `BIT_CH1_IRQ) & {8{load[0]}}
                   | (8'h01 << `BIT_CH2_IRQ) & {8{load[1]}};
  wire [7:0] set_b = (8'h01 << `BIT_CH3_IRQ) & {8{load[2]}}
                   | (8'h01 << `BIT_CH4_IRQ) & {8{load[3]}};
  wire [7:0] clr_a = (wr && hit_fl_a) ? wb : 8'h00;
  wire [7:0] clr_b = (wr && hit_fl_b) ? wb : 8'h00;
  wire [7:0] fl_a_d = (irq_flags_a_q & ~clr_a) | set_a;
  wire [7:0] fl_b_d = (irq_flags_b_q & ~clr_b) | set_b;

  // Flag register, first group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flags_a_q <= `RST_IRQ_FLAGS;
    end else begin
      irq_flags_a_q <= fl_a_d;
    end
  end

  // Flag register, second group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flags_b_q <= `RST_IRQ_FLAGS;
    end else begin
      irq_flags_b_q <= fl_b_d;
    end
  end

  // Level interrupt from the next flags, so a new event shows at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(fl_a_d & irq_en_a_q) || |(fl_b_d & irq_en_b_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state, data captured in it

  // Ready rises after the first access cycle and stands one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup_acc;
    end
  end

  // Read data latched in the wait state, before any read side effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_acc) begin
      prdata_q <= (addr_ok && !pwrite) ? {24'h000000, rmux} : 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign irq    = irq_q;

endmodule

// ### src/capture_readout_params.svh
// Register indices, banks, field positions and reset values
`ifndef CAPTURE_READOUT_PARAMS_SVH
`define CAPTURE_READOUT_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_BANK_SELECT      5'h0F
`define IDX_IRQ_FLAGS_B      5'h10
`define IDX_IRQ_ENABLES_B    5'h11
`define IDX_TB_LOW           5'h12
`define IDX_TB_HIGH          5'h13
`define IDX_CH3_LOW          5'h12
`define IDX_CH3_HIGH         5'h13
`define IDX_CH2_LOW          5'h14
`define IDX_CH2_HIGH         5'h15
`define IDX_CH4_LOW          5'h14
`define IDX_CH4_HIGH         5'h15
`define IDX_EDGE_CLOCK_CTRL  5'h16
`define IDX_UPPER_CTRL       5'h16
`define IDX_IRQ_FLAGS_A      5'h16
`define IDX_PER_CH1_LOW      5'h16
`define IDX_RUN_OVF_STATUS   5'h17
`define IDX_IRQ_ENABLES_A    5'h17
`define IDX_PER_CH1_HIGH     5'h17

// Peripheral banks
`define BANK_IRQ_A           4'h1
`define BANK_TIMEBASE        4'h2
`define BANK_TIMER_CTRL      4'h3
`define BANK_IRQ_B           4'h4
`define BANK_UPPER           4'h7

// Field positions
`define BIT_CH1_IRQ          2
`define BIT_CH2_IRQ          3
`define BIT_CH3_IRQ          2
`define BIT_CH4_IRQ          3
`define BIT_CH2_OVF          7
`define BIT_CH1_OVF          6
`define BIT_PERIOD_CAP_SEL   3
`define BIT_TIMEBASE_RUN     2
`define BIT_CH4_OVF          6
`define BIT_CH3_OVF          5
`define BIT_UPPER_RSVD       7

// Reset values
`define RST_IRQ_FLAGS        8'h02
`define RST_IRQ_ENABLES      8'h00
`define RST_TIMER_CTRL       8'h00
`define RST_BANK             4'h0

`endif

// ### src/capture_readout_pkg.sv
// Shared types of the capture readout block
package capture_readout_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] cap_word_t;
  typedef logic [3:0]  bank_t;
  typedef logic [4:0]  reg_idx_t;
endpackage
